// file: rtl/udc_params.svh
// constants for the eight-bit up/down counter: widths, values, register map
`ifndef UDC_PARAMS_SVH
`define UDC_PARAMS_SVH

// ----------------------------------------------------------------------------
// counter value range
// ----------------------------------------------------------------------------
`define UDC_WIDTH 8
`define UDC_COUNT_ZERO 8'h00
`define UDC_COUNT_MAX 8'hff
`define UDC_COUNT_STEP 8'h01

// ----------------------------------------------------------------------------
// register port map (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define UDC_ADDR_W 4
`define UDC_DATA_W 32
`define UDC_REG_CTRL 4'h0
`define UDC_REG_LOAD 4'h4
`define UDC_REG_COUNT 4'h8
`define UDC_REG_STATUS 4'hc

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define UDC_CTRL_OVR_BIT 0
`define UDC_CTRL_SEL_LO_BIT 1
`define UDC_CTRL_SEL_HI_BIT 2
`define UDC_CTRL_PAR_BIT 3
`define UDC_CTRL_TRK_BIT 4
`define UDC_STAT_CARRY_BIT 0
`define UDC_STAT_MODE_LO_BIT 1
`define UDC_STAT_MODE_HI_BIT 2
`define UDC_STAT_WRAP_BIT 3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define UDC_CTRL_RST 5'h18
`define UDC_LOAD_RST 8'h00
`define UDC_RDATA_RST 32'h0000_0000

`endif

// file: rtl/udc_pkg.sv
// types shared by the up/down counter modules
package udc_pkg;

    // ------------------------------------------------------------------------
    // function select, coded as {func_select_hi, func_select_lo}
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        UDC_MODE_CLEAR = 2'b00,
        UDC_MODE_DOWN  = 2'b01,
        UDC_MODE_LOAD  = 2'b10,
        UDC_MODE_UP    = 2'b11
    } udc_mode_e;

    typedef logic [7:0] udc_count_t;

endpackage

// file: rtl/udc_ctl_if.sv
// control signals between the counter core, its decoder and its carry logic
`timescale 1ns/1ps
interface udc_ctl_if;
    import udc_pkg::*;

    logic func_select_lo;
    logic func_select_hi;
    logic parallel_count_gate_n;
    logic trickle_count_gate_n;
    udc_mode_e mode;
    logic clear_now;
    logic load_now;
    logic count_go;
    logic count_up;

    modport core (
        output func_select_lo,
        output func_select_hi,
        output parallel_count_gate_n,
        output trickle_count_gate_n,
        input mode,
        input clear_now,
        input load_now,
        input count_go,
        input count_up
    );

    modport dec (
        input func_select_lo,
        input func_select_hi,
        input parallel_count_gate_n,
        input trickle_count_gate_n,
        output mode,
        output clear_now,
        output load_now,
        output count_go,
        output count_up
    );

    modport carry (
        input mode,
        input trickle_count_gate_n,
        input parallel_count_gate_n
    );
endinterface

// file: rtl/udc_mode_decode.sv
// decodes the function select and count gates into the counter's actions
`timescale 1ns/1ps
module udc_mode_decode
    import udc_pkg::*;
(
    udc_ctl_if.dec ctl
);

    logic gates_open;

    always_comb begin
        ctl.mode = udc_mode_e'({ctl.func_select_hi, ctl.func_select_lo});
        gates_open = ~ctl.parallel_count_gate_n & ~ctl.trickle_count_gate_n;
        ctl.clear_now = 1'b0;
        ctl.load_now = 1'b0;
        ctl.count_go = 1'b0;
        ctl.count_up = 1'b0;
        unique case (ctl.mode)
            UDC_MODE_CLEAR: begin
                ctl.clear_now = 1'b1;
            end
            UDC_MODE_DOWN: begin
                ctl.count_go = gates_open;
            end
            UDC_MODE_LOAD: begin
                ctl.load_now = 1'b1;
            end
            UDC_MODE_UP: begin
                ctl.count_go = gates_open;
                ctl.count_up = 1'b1;
            end
        endcase
    end

endmodule

// file: rtl/udc_carry_detect.sv
// terminal count detection feeding the active-low carry out
`timescale 1ns/1ps
`include "udc_params.svh"
module udc_carry_detect
    import udc_pkg::*;
(
    udc_ctl_if.carry ctl,
    input wire udc_count_t count_i,
    output logic carry_n_o
);

    always_comb begin
        carry_n_o = 1'b1;
        if (!ctl.trickle_count_gate_n && !ctl.parallel_count_gate_n) begin
            if (ctl.mode == UDC_MODE_DOWN && count_i == `UDC_COUNT_ZERO) begin
                carry_n_o = 1'b0;
            end else if (ctl.mode == UDC_MODE_UP && count_i == `UDC_COUNT_MAX) begin
                carry_n_o = 1'b0;
            end
        end
    end

endmodule

// file: rtl/updown_counter_8bit.sv
// eight-bit presettable up/down counter with asynchronous clear and register port
//
// Functional notes
// - all eight count flops share one rising clock edge.
// - count is 8-bit binary; up adds one, down subtracts one, wrapping.
// - selects: 00 clear, 01 count down, 10 load, 11 count up.
// - clear select forces the count to zero immediately, no clock needed.
// - load select takes the parallel data on the next rising edge.
// - count advances only with both gates low in a counting mode.
// - counting down with both count gates low, carry is low at zero.
// - counting up with both count gates low, carry is low at 255.
// - carry is high whenever either count gate is high.
// - gate changes allowed any time; only levels at the edge matter.
// - hold, load or count decided only by levels at the rising edge.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "udc_params.svh"
module updown_counter_8bit
    import udc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic func_select_lo_i,
    input wire logic func_select_hi_i,
    input wire logic parallel_count_gate_n_i,
    input wire logic trickle_count_gate_n_i,
    input wire logic [7:0] load_data_i,
    output logic [7:0] count_o,
    output logic terminal_carry_n_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    udc_ctl_if ctl ();

    logic [4:0] ctrl_q;
    logic [4:0] ctrl_d;
    udc_count_t sw_load_q;
    udc_count_t sw_load_d;
    logic wrap_q;
    logic wrap_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    udc_count_t count_q;
    udc_count_t count_d;
    udc_count_t load_bits;
    logic sw_override;
    logic clear_async;
    logic carry_n;
    logic wrap_event;
    logic wrap_clear;

    // ------------------------------------------------------------------------
    // input selection: pins, or software override from the control register
    // ------------------------------------------------------------------------
    assign sw_override = ctrl_q[`UDC_CTRL_OVR_BIT];

    // load and count inputs are sampled as synchronous levels; the clear select and the carry act at once
    always_comb begin
        if (sw_override) begin
            ctl.func_select_lo = ctrl_q[`UDC_CTRL_SEL_LO_BIT];
            ctl.func_select_hi = ctrl_q[`UDC_CTRL_SEL_HI_BIT];
            ctl.parallel_count_gate_n = ctrl_q[`UDC_CTRL_PAR_BIT];
            ctl.trickle_count_gate_n = ctrl_q[`UDC_CTRL_TRK_BIT];
        end else begin
            ctl.func_select_lo = func_select_lo_i;
            ctl.func_select_hi = func_select_hi_i;
            ctl.parallel_count_gate_n = parallel_count_gate_n_i;
            ctl.trickle_count_gate_n = trickle_count_gate_n_i;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `UDC_WIDTH; gi++) begin : g_load_bit
            assign load_bits[gi] = sw_override ? sw_load_q[gi] : load_data_i[gi];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // decode and carry
    // ------------------------------------------------------------------------
    udc_mode_decode u_decode (
        .ctl (ctl)
    );

    udc_carry_detect u_carry (
        .ctl (ctl),
        .count_i (count_q),
        .carry_n_o (carry_n)
    );

    // carry must follow the gates without a clock, so it is not registered
    assign terminal_carry_n_o = carry_n;

    // ------------------------------------------------------------------------
    // counter core
    // ------------------------------------------------------------------------
    // clear select acts as an asynchronous reset of the count flops; a
    // direct load-to-down switch must not let both selects sit low, or it clears
    assign clear_async = rst_i | ctl.clear_now;

    always_comb begin
        count_d = count_q;
        if (ctl.load_now) begin
            count_d = load_bits;
        end else if (ctl.count_go) begin
            if (ctl.count_up) begin
                count_d = count_q + `UDC_COUNT_STEP;
            end else begin
                count_d = count_q - `UDC_COUNT_STEP;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge clear_async) begin
        if (clear_async) begin
            count_q <= `UDC_COUNT_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    assign count_o = count_q;

    // ------------------------------------------------------------------------
    // wrap tracking: a count step taken while the carry is low
    // ------------------------------------------------------------------------
    assign wrap_event = ctl.count_go & ~carry_n;
    assign wrap_clear = reg_we_i & (reg_addr_i == `UDC_REG_STATUS) & reg_wdata_i[`UDC_STAT_WRAP_BIT];

    // a new wrap in the clearing cycle stays set
    always_comb begin
        wrap_d = wrap_q;
        if (wrap_clear) begin
            wrap_d = 1'b0;
        end
        if (wrap_event) begin
            wrap_d = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        sw_load_d = sw_load_q;
        if (reg_we_i) begin
            unique case (reg_addr_i)
                `UDC_REG_CTRL: begin
                    ctrl_d = reg_wdata_i[4:0];
                end
                `UDC_REG_LOAD: begin
                    sw_load_d = reg_wdata_i[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rdata_d = `UDC_RDATA_RST;
        if (reg_re_i) begin
            unique case (reg_addr_i)
                `UDC_REG_CTRL: begin
                    rdata_d[4:0] = ctrl_q;
                end
                `UDC_REG_LOAD: begin
                    rdata_d[7:0] = sw_load_q;
                end
                `UDC_REG_COUNT: begin
                    rdata_d[7:0] = count_q;
                end
                `UDC_REG_STATUS: begin
                    rdata_d[`UDC_STAT_CARRY_BIT] = carry_n;
                    rdata_d[`UDC_STAT_MODE_HI_BIT:`UDC_STAT_MODE_LO_BIT] = ctl.mode;
                    rdata_d[`UDC_STAT_WRAP_BIT] = wrap_q;
                end
                default: begin
                end
            endcase
        end
    end

    // register state survives the clear select; only rst_i resets it
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= `UDC_CTRL_RST;
            sw_load_q <= `UDC_LOAD_RST;
            wrap_q <= 1'b0;
            rdata_q <= `UDC_RDATA_RST;
        end else begin
            ctrl_q <= ctrl_d;
            sw_load_q <= sw_load_d;
            wrap_q <= wrap_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule

// file: dv/updown_counter_8bit_chk.sv
// assertion checker on the counter pins
`timescale 1ns/1ps
module udc_checker
    import udc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic func_select_lo_i,
    input wire logic func_select_hi_i,
    input wire logic parallel_count_gate_n_i,
    input wire logic trickle_count_gate_n_i,
    input wire logic [7:0] load_data_i,
    input wire logic [7:0] count_o,
    input wire logic terminal_carry_n_o
);
    wire logic [1:0] sel = {func_select_hi_i, func_select_lo_i};
    wire logic go = !parallel_count_gate_n_i && !trickle_count_gate_n_i;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // --------------------
    // sequences
    // --------------------
    // a clear in the next cycle overrides any synchronous result
    sequence s_live;
        sel != UDC_MODE_CLEAR;
    endsequence
    sequence s_up;
        sel == UDC_MODE_UP && go;
    endsequence
    sequence s_dn;
        sel == UDC_MODE_DOWN && go;
    endsequence
    // --------------------
    // properties
    // --------------------
    property p_clear;
        sel == UDC_MODE_CLEAR |-> count_o == 8'h00;
    endproperty
    property p_load;
        sel == UDC_MODE_LOAD ##1 s_live |-> count_o == $past(load_data_i);
    endproperty
    property p_up;
        s_up ##1 s_live |-> count_o == 8'($past(count_o) + 8'h01);
    endproperty
    property p_dn;
        s_dn ##1 s_live |-> count_o == 8'($past(count_o) - 8'h01);
    endproperty
    property p_hold;
        sel[0] && !go ##1 s_live |-> $stable(count_o);
    endproperty
    property p_carry_dn;
        s_dn |-> terminal_carry_n_o == (count_o != 8'h00);
    endproperty
    property p_carry_up;
        s_up |-> terminal_carry_n_o == (count_o != 8'hff);
    endproperty
    property p_carry_gate;
        !go |-> terminal_carry_n_o;
    endproperty
    a_clear: assert property (p_clear) else $error("count not zero in clear");
    a_load: assert property (p_load) else $error("load data not taken");
    a_up: assert property (p_up) else $error("up step wrong");
    a_dn: assert property (p_dn) else $error("down step wrong");
    a_hold: assert property (p_hold) else $error("count moved while gated");
    a_carry_dn: assert property (p_carry_dn) else $error("carry wrong counting down");
    a_carry_up: assert property (p_carry_up) else $error("carry wrong counting up");
    a_carry_gate: assert property (p_carry_gate) else $error("carry low with gate high");
endmodule

bind updown_counter_8bit udc_checker u_chk (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .func_select_lo_i(func_select_lo_i),
    .func_select_hi_i(func_select_hi_i),
    .parallel_count_gate_n_i(parallel_count_gate_n_i),
    .trickle_count_gate_n_i(trickle_count_gate_n_i),
    .load_data_i(load_data_i),
    .count_o(count_o),
    .terminal_carry_n_o(terminal_carry_n_o)
);

// file: dv/udc_cascade_stage.sv
// upper byte of a two-stage cascade, stepped by the counter's carry
`timescale 1ns/1ps
module udc_cascade_stage
    import udc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic carry_n_i,
    output udc_count_t upper_o
);
    udc_count_t upper_q;
    udc_count_t upper_d;
    always_comb begin
        // low carry stands in for both gates of this stage
        upper_d = carry_n_i ? upper_q : 8'(upper_q + 8'h01);
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            upper_q <= 8'h00;
        end else begin
            upper_q <= upper_d;
        end
    end
    assign upper_o = upper_q;
endmodule

// file: dv/updown_counter_8bit_bench.sv
// self-checking bench for the up/down counter
`timescale 1ns/1ps
module updown_counter_8bit_bench
    import udc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic s_lo = 1'b1;
    logic s_hi = 1'b1;
    logic gp_n = 1'b1;
    logic gt_n = 1'b1;
    logic [7:0] ld = 8'h00;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] count;
    logic carry_n;
    logic [31:0] rdata;
    udc_count_t upper;
    int err_count = 0;
    int total_checks = 0;
    int cycle_count = 0;

    always #4 clk = ~clk;

    updown_counter_8bit uut (
        .core_clk_i(clk), .rst_i(rst), .func_select_lo_i(s_lo), .func_select_hi_i(s_hi),
        .parallel_count_gate_n_i(gp_n), .trickle_count_gate_n_i(gt_n), .load_data_i(ld),
        .count_o(count), .terminal_carry_n_o(carry_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata)
    );
    udc_cascade_stage u_stage (.core_clk_i(clk), .rst_i(rst), .carry_n_i(carry_n), .upper_o(upper));

    // --------------------
    // tasks
    // --------------------
    task automatic finish_test();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    // the edge that applies new pins still acts on the old ones
    task automatic drv(input udc_mode_e m, input logic p, input logic t, input logic [7:0] d);
        @(posedge clk);
        {s_hi, s_lo} <= m;
        gp_n <= p;
        gt_n <= t;
        ld <= d;
        #1;
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    always @(posedge clk) begin
        cycle_count++;
        if (cycle_count == 1000) begin
            err_count++;
            finish_test();
        end
    end

    // --------------------
    // tests
    // --------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, 32'h0000_0018);
        rd(4'h2, 32'h0000_0000);
        wr(4'h4, 32'h0000_00a5);
        rd(4'h4, 32'h0000_00a5);
        wr(4'h8, 32'h0000_00ff);
        rd(4'h8, 32'h0000_0000);
        wr(4'h0, 32'h0000_001e);
        rd(4'h0, 32'h0000_001e);
        rd(4'hc, 32'h0000_0007);
        drv(UDC_MODE_LOAD, 1'b1, 1'b1, 8'hfe);
        drv(UDC_MODE_UP, 1'b1, 1'b1, 8'h00);
        check(count, 8'hfe);
        drv(UDC_MODE_UP, 1'b0, 1'b0, 8'h00);
        check(carry_n, 1'b1);
        tick();
        check({carry_n, count}, 9'h0ff);
        tick();
        check({upper, carry_n, count}, 17'h0_0300);
        drv(UDC_MODE_UP, 1'b1, 1'b0, 8'h00);
        repeat (3) tick();
        check({carry_n, count}, 9'h101);
        drv(UDC_MODE_LOAD, 1'b0, 1'b0, 8'h00);
        drv(UDC_MODE_DOWN, 1'b0, 1'b1, 8'h00);
        check({carry_n, count}, 9'h100);
        drv(UDC_MODE_DOWN, 1'b1, 1'b0, 8'h00);
        check({carry_n, count}, 9'h100);
        drv(UDC_MODE_DOWN, 1'b0, 1'b0, 8'h00);
        check({carry_n, count}, 9'h000);
        tick();
        check({upper, carry_n, count}, 17'h0_05ff);
        drv(UDC_MODE_DOWN, 1'b1, 1'b1, 8'h00);
        rd(4'hc, 32'h0000_000b);
        wr(4'hc, 32'h0000_0008);
        rd(4'hc, 32'h0000_0003);
        rd(4'h8, 32'h0000_00fe);
        drv(UDC_MODE_CLEAR, 1'b1, 1'b1, 8'h00);
        check(count, 8'h00);
        drv(UDC_MODE_LOAD, 1'b1, 1'b1, 8'h5a);
        drv(UDC_MODE_UP, 1'b1, 1'b1, 8'h00);
        check(count, 8'h5a);
        // override on, selects count down with gates high; pins stay count up
        wr(4'h0, 32'h0000_001b);
        rd(4'hc, 32'h0000_0003);
        rd(4'h8, 32'h0000_005a);
        @(posedge clk);
        rst <= 1'b1;
        #1;
        check({upper, count}, 16'h0000);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, 32'h0000_0018);
        finish_test();
    end
endmodule
